// ### verilog/dhiu_pkg.sv
// Constants, word layout and engine states of the DAC host interface.
// Assumes a single 200 MHz core clock; every pin is asynchronous to it.
package dhiu_pkg;
	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int DATA_W = 14;
	localparam int ADDR_W = 8;
	localparam int CHANNELS = 32;
	localparam int WORD_W = 24;
	localparam int QUEUE_DEPTH = 4;
	localparam logic [4:0] WORD_BITS = 5'h18;
	localparam logic [4:0] LAST_CH = 5'h1f;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int RESET_TIME_US = 100;
	localparam int RESET_CYCLES =
		(RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register-select codes and address groups
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_DATA = 2'h3;
	localparam logic [1:0] SEL_OFFSET = 2'h2;
	localparam logic [1:0] SEL_GAIN = 2'h1;
	localparam logic [1:0] SEL_SPECIAL = 2'h0;
	localparam int SOFT_RST_BIT = 13;
	localparam logic [3:0] GRP_ALL = 4'h0;
	localparam logic [3:0] GRP_FIRST = 4'h1;

	// ----------------------------------------------------------------
	// Reset values and scale
	// ----------------------------------------------------------------
	localparam logic [13:0] INPUT_RST = 14'h0000;
	localparam logic [13:0] GAIN_RST = 14'h3fff;
	localparam logic [13:0] OFFSET_RST = 14'h2000;
	localparam logic [13:0] CAL_RST = 14'h0000;
	localparam logic [13:0] MID_SCALE = 14'h2000;
	localparam logic [13:0] FULL_SCALE = 14'h3fff;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] regsel;
		logic [7:0] addr;
		logic [13:0] data;
	} dhiu_word_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_WRITE = 2'b01,
		ENG_CALC = 2'b10
	} dhiu_eng_t;
endpackage

// ### verilog/dhiu_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on core_clk.
`timescale 1ns/100ps
module dhiu_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r;
	logic push, pop;

	// Wraps correctly for depths that are not a power of two
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1))
			return '0;
		return p + AW'(1);
	endfunction

	assign in_ready = cnt_r != FULL_CNT;
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rp_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= next_ptr(wp_r);
			if (pop)
				rp_r <= next_ptr(rp_r);
			if (push && !pop)
				cnt_r <= cnt_r + (AW + 1)'(1);
			else if (pop && !push)
				cnt_r <= cnt_r - (AW + 1)'(1);
		end
	end
endmodule

// ### verilog/dhiu_top.sv
// Host interface and output-update control of a 32-channel DAC.
// Assumes all pins asynchronous to core_clk; serial clock well below it.
//
// Behaviour
// - Serial port when interface select high, parallel port when low.
// - Shift serial bits in on each serial clock falling edge.
// - Launch serial output bits on rising edges for chained parts.
// - Daisy-chain only with chain enable high and serial mode selected.
// - Parallel port selected only while chip select is low.
// - Parallel write taken on write strobe rising edge with chip select low.
// - Parallel data is 14 bits, top bit most significant.
// - Upper address bits select one group or all groups.
// - Register select picks data, gain, offset or special function.
// - Clear low grounds all outputs and ignores load strobes.
// - Outputs stay cleared until next load; registers keep contents.
// - Busy low during calculation; writes queue if queue enabled, else lost; no output updates.
// - Load while not busy copies calibrated values to outputs at once.
// - Load while busy is remembered and done when busy releases.
// - Busy is open drain, sensed back so others can hold it low.
// - Busy low during reset; parallel port off, loads discarded.
// - Reset pin fall runs a 100 us reset restoring all registers.
// - Queue enable high enables the write queue in both modes.
`timescale 1ns/100ps
module dhiu_top import dhiu_pkg::*; #(
	parameter logic [15:0] RST_SEQ_CYCLES = 16'(RESET_CYCLES)
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reset_pin_n,
	// Mode straps
	input wire logic interface_select,
	input wire logic chain_enable,
	input wire logic queue_enable,
	// Serial port
	input wire logic frame_sync_n,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	output logic serial_data_out,
	// Parallel port
	input wire logic chip_select_n,
	input wire logic write_strobe,
	input wire logic register_select_hi,
	input wire logic register_select_lo,
	input wire logic [ADDR_W-1:0] address_bus,
	input wire logic [DATA_W-1:0] parallel_data,
	// Update control
	input wire logic clear_n,
	input wire logic load_outputs_n,
	input wire logic busy_in,
	output logic busy_out,
	output logic busy_oe,
	// Channel values
	output logic reference_ground,
	output logic [CHANNELS-1:0][DATA_W-1:0] channel_outputs
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int PIN_W = 24 + 12;
	logic [PIN_W-1:0] pins, meta_r, sync_r;
	logic rpin_s, sel_s, chain_enable_s, qen_s, frm_s, sck_s, sdi_s, cs_s, wr_s;
	logic clr_s, ld_s, busy_s;
	logic [1:0] rsel_s;
	logic [ADDR_W-1:0] adr_s;
	logic [DATA_W-1:0] dat_s;
	logic sck_q, wr_q, ld_q, rpin_q, frm_q;

	assign pins = {reset_pin_n, interface_select, chain_enable,
		queue_enable, frame_sync_n, serial_clock, serial_data_in,
		chip_select_n, write_strobe, register_select_hi,
		register_select_lo, clear_n, load_outputs_n, busy_in,
		address_bus, parallel_data};
	assign {rpin_s, sel_s, chain_enable_s, qen_s, frm_s, sck_s, sdi_s, cs_s,
		wr_s, rsel_s, clr_s, ld_s, busy_s, adr_s, dat_s} = sync_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			sync_r <= '0;
			{sck_q, wr_q, ld_q, rpin_q, frm_q} <= '0;
		end else begin
			meta_r <= pins;
			sync_r <= meta_r;
			{sck_q, wr_q, ld_q, rpin_q, frm_q} <=
				{sck_s, wr_s, ld_s, rpin_s, frm_s};
		end
	end

	logic sck_fall, sck_rise, wr_rise, ld_fall, rpin_fall, frm_fall;
	logic frm_rise;
	assign sck_fall = sck_q & ~sck_s;
	assign sck_rise = ~sck_q & sck_s;
	assign wr_rise = ~wr_q & wr_s;
	assign ld_fall = ld_q & ~ld_s;
	assign rpin_fall = rpin_q & ~rpin_s;
	assign frm_fall = frm_q & ~frm_s;
	assign frm_rise = ~frm_q & frm_s;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Group 0 broadcasts to all groups, groups 1 to 4 hold 8 channels
	function automatic logic chan_hit(input logic [7:0] a,
		input logic [4:0] ch);
		logic [3:0] g;
		g = a[7:4];
		return !a[3] && (a[2:0] == ch[2:0]) &&
			(g == GRP_ALL || g == {2'b00, ch[4:3]} + GRP_FIRST);
	endfunction

	// x * (m + 1) / 2^14 + c - midscale, clamped to the code range
	function automatic logic [13:0] cal_value(input logic [13:0] x,
		input logic [13:0] m, input logic [13:0] c);
		logic [28:0] prod;
		logic [16:0] sum;
		prod = {15'h0000, x} * {14'h0000, {1'b0, m} + 15'h0001};
		sum = {2'b00, prod[28:14]} + {3'b000, c} - {3'b000, MID_SCALE};
		if (sum[16])
			return '0;
		if (sum[15:14] != 2'b00)
			return FULL_SCALE;
		return sum[13:0];
	endfunction

	// ----------------------------------------------------------------
	// Reset sequence
	// ----------------------------------------------------------------
	logic [15:0] seq_cnt_r;
	logic soft_rst, seq_start, hold;

	assign seq_start = rpin_fall | soft_rst;
	assign hold = (seq_cnt_r != 16'h0000) | ~rpin_s;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			seq_cnt_r <= RST_SEQ_CYCLES;
		else if (seq_start)
			seq_cnt_r <= RST_SEQ_CYCLES;
		else if (seq_cnt_r != 16'h0000)
			seq_cnt_r <= seq_cnt_r - 16'h0001;
	end

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	logic ser_mode, chain_mode, frame_on, ser_take;
	logic [WORD_W-1:0] shreg_r, ser_word;
	logic [4:0] bit_cnt_r;
	logic sdo_r;

	assign ser_mode = sel_s;
	assign chain_mode = sel_s & chain_enable_s;
	assign frame_on = ser_mode & ~frm_s;
	// Chain mode keeps the last 24 bits shifted before the frame ends
	assign ser_take = ser_mode & (chain_mode ?
		(frm_rise & bit_cnt_r == WORD_BITS) :
		(sck_fall & frame_on & bit_cnt_r == WORD_BITS - 5'h01));
	assign ser_word = chain_mode ? shreg_r : {shreg_r[22:0], sdi_s};

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shreg_r <= '0;
			bit_cnt_r <= '0;
		end else begin
			if (sck_fall && frame_on)
				shreg_r <= {shreg_r[22:0], sdi_s};
			if (frm_fall)
				bit_cnt_r <= '0;
			else if (sck_fall && frame_on && bit_cnt_r != WORD_BITS)
				bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			sdo_r <= 1'b0;
		else if (!chain_mode)
			sdo_r <= 1'b0;
		else if (sck_rise && frame_on)
			sdo_r <= shreg_r[23];
	end
	assign serial_data_out = sdo_r;

	// ----------------------------------------------------------------
	// Parallel port and write queue
	// ----------------------------------------------------------------
	logic par_take, wr_ready, q_in_ready, q_out_valid, q_out_ready;
	dhiu_word_t par_word, in_word, q_word, cur_r;
	dhiu_eng_t eng_r;

	// Selected only with chip select low
	assign par_take = ~sel_s & ~cs_s & wr_rise & ~hold;
	// Data bit 13 is the MSB
	assign par_word = {rsel_s, adr_s, dat_s};
	assign in_word = sel_s ? dhiu_word_t'(ser_word) : par_word;
	// Queue off means one word at a time
	// Words arriving when not ready are lost; host must honour busy
	assign wr_ready = q_in_ready &
		(qen_s | (~q_out_valid & eng_r == ENG_IDLE));
	// Discard queued words while reset holds
	assign q_out_ready = hold | (eng_r == ENG_IDLE);

	dhiu_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(QUEUE_DEPTH)
	) u_queue (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid((ser_take | par_take) & wr_ready & ~hold),
		.in_ready(q_in_ready),
		.in_data(in_word),
		.out_valid(q_out_valid),
		.out_ready(q_out_ready),
		.out_data(q_word)
	);

	// ----------------------------------------------------------------
	// Calibration engine
	// ----------------------------------------------------------------
	logic [4:0] ch_r;
	logic [DATA_W-1:0] x1_r [CHANNELS];
	logic [DATA_W-1:0] gain_r [CHANNELS];
	logic [DATA_W-1:0] offs_r [CHANNELS];
	logic [DATA_W-1:0] cal_r [CHANNELS];

	assign soft_rst = (eng_r == ENG_WRITE) &
		(cur_r.regsel == SEL_SPECIAL) & cur_r.data[SOFT_RST_BIT];

	// One channel per cycle trades time for a single multiplier
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			eng_r <= ENG_IDLE;
			cur_r <= '0;
			ch_r <= '0;
		end else if (hold || seq_start) begin
			eng_r <= ENG_IDLE;
		end else begin
			case (eng_r)
			ENG_IDLE: begin
				if (q_out_valid) begin
					cur_r <= q_word;
					eng_r <= ENG_WRITE;
				end
			end
			ENG_WRITE: begin
				ch_r <= '0;
				eng_r <= (cur_r.regsel == SEL_SPECIAL) ? ENG_IDLE : ENG_CALC;
			end
			ENG_CALC: begin
				ch_r <= ch_r + 5'h01;
				if (ch_r == LAST_CH)
					eng_r <= ENG_IDLE;
			end
			default: eng_r <= ENG_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < CHANNELS; i++) begin
				x1_r[i] <= INPUT_RST;
				gain_r[i] <= GAIN_RST;
				offs_r[i] <= OFFSET_RST;
				cal_r[i] <= CAL_RST;
			end
		end else if (seq_start) begin
			for (int i = 0; i < CHANNELS; i++) begin
				x1_r[i] <= INPUT_RST;
				gain_r[i] <= GAIN_RST;
				offs_r[i] <= OFFSET_RST;
				cal_r[i] <= CAL_RST;
			end
		end else if (eng_r == ENG_WRITE && !hold) begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (chan_hit(cur_r.addr, 5'(i))) begin
					if (cur_r.regsel == SEL_DATA)
						x1_r[i] <= cur_r.data;
					if (cur_r.regsel == SEL_GAIN)
						gain_r[i] <= cur_r.data;
					if (cur_r.regsel == SEL_OFFSET)
						offs_r[i] <= cur_r.data;
				end
			end
		end else if (eng_r == ENG_CALC && !hold) begin
			if (chan_hit(cur_r.addr, ch_r))
				cal_r[ch_r] <= cal_value(x1_r[ch_r], gain_r[ch_r],
					offs_r[ch_r]);
		end
	end

	// ----------------------------------------------------------------
	// Busy line and load control
	// ----------------------------------------------------------------
	logic int_busy, busy_ok, ld_ok, do_update, pending_r, grounded_r;

	// Busy while queue or engine work remains
	assign int_busy = (eng_r != ENG_IDLE) | q_out_valid | hold;
	// Open drain, only ever pulls low
	assign busy_out = 1'b0;
	assign busy_oe = int_busy;
	// Wired-AND of own busy and sensed line
	assign busy_ok = busy_s & ~int_busy;
	assign ld_ok = ld_fall & ~hold & clr_s;
	assign do_update = clr_s & ~hold & busy_ok & (ld_ok | pending_r);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			pending_r <= 1'b0;
		else if (hold || !clr_s)
			pending_r <= 1'b0;
		else if (ld_ok && !busy_ok)
			pending_r <= 1'b1;
		else if (do_update)
			pending_r <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			grounded_r <= 1'b1;
		else if (hold || !clr_s)
			grounded_r <= 1'b1;
		else if (do_update)
			grounded_r <= 1'b0;
	end
	assign reference_ground = grounded_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < CHANNELS; i++)
				channel_outputs[i] <= CAL_RST;
		end else if (do_update) begin
			for (int i = 0; i < CHANNELS; i++)
				channel_outputs[i] <= cal_r[i];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	par_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		par_take |-> !sel_s && !cs_s && !hold)
		else $error("parallel write outside parallel select");
	shift_count_a: assert property (@(posedge core_clk)
		disable iff (!rst_b) (sck_fall && frame_on && !frm_fall &&
		bit_cnt_r != WORD_BITS) |=> bit_cnt_r == $past(bit_cnt_r) + 5'h01)
		else $error("serial bit not counted");
	sdo_launch_a: assert property (@(posedge core_clk)
		disable iff (!rst_b) (sck_rise && frame_on && chain_mode) |=>
		serial_data_out == $past(shreg_r[23]))
		else $error("serial output bit not launched");
	sdo_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		!chain_mode |=> !serial_data_out)
		else $error("serial output active outside chain mode");
	clear_block_a: assert property (@(posedge core_clk)
		disable iff (!rst_b) !clr_s |=> grounded_r && !pending_r)
		else $error("clear did not ground outputs");
	clear_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(grounded_r && !do_update) |=> grounded_r)
		else $error("outputs left ground without a load");
	busy_update_a: assert property (@(posedge core_clk)
		disable iff (!rst_b) int_busy |-> !do_update)
		else $error("output update while busy");
	load_now_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(ld_ok && busy_ok) |=> !grounded_r &&
		channel_outputs[0] == $past(cal_r[0]))
		else $error("load not applied at once");
	load_defer_a: assert property (@(posedge core_clk)
		disable iff (!rst_b) (ld_ok && !busy_ok && clr_s && !hold) |=>
		pending_r || !clr_s || hold)
		else $error("deferred load lost");
	reset_busy_a: assert property (@(posedge core_clk)
		disable iff (!rst_b) rpin_fall |=> busy_oe[*8])
		else $error("busy not held during reset");
	reset_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		seq_start |=> seq_cnt_r == RST_SEQ_CYCLES)
		else $error("reset sequence length wrong");
	queue_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!qen_s && q_out_valid) |-> !wr_ready)
		else $error("queue accepted word while disabled");
endmodule

// ### verilog/dhiu_fix_note.sv
// Reserved file; holds no logic.

// ### sim/dhiu_host_model.sv
// Host-side model: serial and parallel write ports plus the busy line.
// Assumes the bench clock is core_clk; every pin it drives except busy_line moves on its falling edge.
`timescale 1ns/100ps
module dhiu_host_model (
	// Clock
	input wire logic core_clk,
	// Serial port
	output logic frame_sync_n,
	output logic serial_clock,
	output logic serial_data_in,
	input wire logic serial_data_out,
	// Parallel port
	output logic chip_select_n,
	output logic write_strobe,
	output logic register_select_hi,
	output logic register_select_lo,
	output logic [7:0] address_bus,
	output logic [13:0] parallel_data,
	// Busy line
	input wire logic busy_out,
	input wire logic busy_oe,
	input wire logic hold_busy,
	output logic busy_line
);
	// ----------------------------------------------------------------
	// Pins and tasks
	// ----------------------------------------------------------------
	logic [47:0] sdo_bits;
	// open drain, pull-up when nobody pulls
	assign busy_line = ((busy_oe && !busy_out) || hold_busy) ? 1'b0 : 1'b1;
	initial begin
		frame_sync_n = 1'b1;
		serial_clock = 1'b0;
		serial_data_in = 1'b0;
		chip_select_n = 1'b1;
		write_strobe = 1'b0;
		{register_select_hi, register_select_lo} = 2'h0;
		address_bus = 8'h00;
		parallel_data = 14'h0000;
		sdo_bits = 48'h0;
	end
	task automatic par_write(input logic cs_n, input logic [1:0] sel,
		input logic [7:0] a, input logic [13:0] d);
		@(negedge core_clk);
		chip_select_n = cs_n;
		{register_select_hi, register_select_lo} = sel;
		address_bus = a;
		parallel_data = d;
		repeat (2) @(negedge core_clk);
		write_strobe = 1'b1;
		repeat (4) @(negedge core_clk);
		write_strobe = 1'b0;
		repeat (2) @(negedge core_clk);
		chip_select_n = 1'b1;
		// Released lines show the inverse, not a stale value
		address_bus = ~a;
		parallel_data = ~d;
	endtask
	// frame held low across all bits
	task automatic ser_frame(input logic [47:0] bits, input int n);
		int i;
		@(negedge core_clk);
		frame_sync_n = 1'b0;
		repeat (13) @(negedge core_clk);
		for (i = n - 1; i >= 0; i--) begin
			serial_clock = 1'b1;
			// data set at rise, steady over the fall
			serial_data_in = bits[i];
			repeat (12) @(negedge core_clk);
			sdo_bits = {sdo_bits[46:0], serial_data_out};
			serial_clock = 1'b0;
			repeat (13) @(negedge core_clk);
		end
		frame_sync_n = 1'b1;
		serial_data_in = ~serial_data_in;
		repeat (4) @(negedge core_clk);
	endtask
endmodule

// ### sim/dhiu_top_test.sv
// Self-checking bench for the DAC host interface and update control.
// Assumes the host model file is compiled first; reset sequence shortened.
`timescale 1ns/100ps
module dhiu_top_test;
	import dhiu_pkg::*;
	// ----------------------------------------------------------------
	// Harness
	// ----------------------------------------------------------------
	logic core_clk, rst_b, reset_pin_n, interface_select, chain_enable;
	logic queue_enable, frame_sync_n, serial_clock, serial_data_in;
	logic serial_data_out, chip_select_n, write_strobe, reference_ground;
	logic register_select_hi, register_select_lo, clear_n, load_outputs_n;
	logic busy_line, busy_out, busy_oe, hold_busy;
	logic [ADDR_W-1:0] address_bus;
	logic [DATA_W-1:0] parallel_data;
	logic [CHANNELS-1:0][DATA_W-1:0] channel_outputs;
	int failures = 0;
	int compares = 0;
	dhiu_top #(.RST_SEQ_CYCLES(16'h0010)) u_dhiu_top (.core_clk(core_clk),
		.rst_b(rst_b), .reset_pin_n(reset_pin_n),
		.interface_select(interface_select), .chain_enable(chain_enable),
		.queue_enable(queue_enable), .frame_sync_n(frame_sync_n),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .chip_select_n(chip_select_n),
		.write_strobe(write_strobe), .register_select_hi(register_select_hi),
		.register_select_lo(register_select_lo), .address_bus(address_bus),
		.parallel_data(parallel_data), .clear_n(clear_n),
		.load_outputs_n(load_outputs_n), .busy_in(busy_line),
		.busy_out(busy_out), .busy_oe(busy_oe),
		.reference_ground(reference_ground),
		.channel_outputs(channel_outputs));
	dhiu_host_model u_host (.core_clk(core_clk), .frame_sync_n(frame_sync_n),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .chip_select_n(chip_select_n),
		.write_strobe(write_strobe), .register_select_hi(register_select_hi),
		.register_select_lo(register_select_lo), .address_bus(address_bus),
		.parallel_data(parallel_data), .busy_out(busy_out),
		.busy_oe(busy_oe), .hold_busy(hold_busy), .busy_line(busy_line));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bounded wait for the busy line and own busy to clear
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (6) @(negedge core_clk);
		while ((busy_line !== 1'b1 || busy_oe !== 1'b0) && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 3000) begin
			failures++;
			$display("BAD busy_idle expected 1 seen 0");
		end
		repeat (2) @(negedge core_clk);
	endtask
	task automatic load_pulse();
		@(negedge core_clk);
		load_outputs_n = 1'b0;
		repeat (4) @(negedge core_clk);
		load_outputs_n = 1'b1;
		repeat (4) @(negedge core_clk);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_par_load();
		u_host.par_write(1'b0, 2'h3, 8'h13, 14'h2a5c);
		// Queue is off, so each word must wait for the engine
		wait_idle();
		u_host.par_write(1'b0, 2'h3, 8'h47, 14'h3fff);
		chk("ch3_before_load", 24'h0, channel_outputs[3]);
		wait_idle();
		load_pulse();
		chk("ch3", 24'h2a5c, channel_outputs[3]);
		chk("ch31", 24'h3fff, channel_outputs[31]);
		chk("ground_after_load", 24'h0, reference_ground);
	endtask
	task automatic t_deselect();
		u_host.par_write(1'b1, 2'h3, 8'h14, 14'h0444);
		interface_select = 1'b1;
		u_host.par_write(1'b0, 2'h3, 8'h14, 14'h0555);
		u_host.ser_frame({24'h0, 2'h3, 8'h12, 14'h1357}, 24);
		chk("sdo_off", 24'h0, u_host.sdo_bits[23:0]);
		wait_idle();
		load_pulse();
		chk("ch4", 24'h0, channel_outputs[4]);
		chk("ch2", 24'h1357, channel_outputs[2]);
	endtask
	task automatic t_chain();
		chain_enable = 1'b1;
		u_host.ser_frame({2'h3, 8'h11, 14'h0f0f, 2'h3, 8'h10, 14'h3001}, 48);
		chk("sdo_chain", {2'h3, 8'h11, 14'h0f0f}, u_host.sdo_bits[23:0]);
		chain_enable = 1'b0;
		interface_select = 1'b0;
		wait_idle();
	endtask
	task automatic t_defer();
		u_host.par_write(1'b0, 2'h3, 8'h15, 14'h1111);
		load_pulse();
		chk("ch5_during_busy", 24'h0, channel_outputs[5]);
		wait_idle();
		// Sensed busy line lags two flops before the stored load acts
		repeat (4) @(negedge core_clk);
		chk("ch5_after_busy", 24'h1111, channel_outputs[5]);
		u_host.par_write(1'b0, 2'h3, 8'h16, 14'h0abc);
		wait_idle();
		hold_busy = 1'b1;
		load_pulse();
		repeat (6) @(negedge core_clk);
		chk("ch6_held", 24'h0, channel_outputs[6]);
		hold_busy = 1'b0;
		repeat (5) @(negedge core_clk);
		chk("ch6_released", 24'h0abc, channel_outputs[6]);
	endtask
	task automatic t_clear();
		clear_n = 1'b0;
		load_pulse();
		chk("ground_clear", 24'h1, reference_ground);
		clear_n = 1'b1;
		repeat (5) @(negedge core_clk);
		chk("ground_kept", 24'h1, reference_ground);
		chk("ch3_kept", 24'h2a5c, channel_outputs[3]);
		load_pulse();
		chk("ground_reload", 24'h0, reference_ground);
		chk("ch3_reload", 24'h2a5c, channel_outputs[3]);
	endtask
	task automatic t_queue();
		int i;
		u_host.par_write(1'b0, 2'h3, 8'h20, 14'h0808);
		u_host.par_write(1'b0, 2'h3, 8'h21, 14'h0909);
		wait_idle();
		queue_enable = 1'b1;
		for (i = 0; i < 4; i++)
			u_host.par_write(1'b0, 2'h3, 8'(8'h22 + i), 14'(14'h0a00 + i));
		wait_idle();
		load_pulse();
		chk("ch8", 24'h0808, channel_outputs[8]);
		chk("ch9_dropped", 24'h0, channel_outputs[9]);
		for (i = 0; i < 4; i++)
			chk("ch_queued", 24'(14'h0a00 + i), channel_outputs[10 + i]);
	endtask
	task automatic t_resets();
		u_host.par_write(1'b0, 2'h0, 8'h00, 14'h2000);
		wait_idle();
		load_pulse();
		chk("ch3_soft", 24'h0, channel_outputs[3]);
		reset_pin_n = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("busy_pin", 24'h1, busy_oe);
		chk("busy_level", 24'h0, busy_out);
		load_pulse();
		chk("ground_pin", 24'h1, reference_ground);
		reset_pin_n = 1'b1;
		wait_idle();
		chk("ground_after_pin", 24'h1, reference_ground);
	endtask
	initial begin
		#200000;
		failures++;
		close_out();
	end
	initial begin
		{rst_b, reset_pin_n, interface_select, chain_enable} = 4'h4;
		{queue_enable, clear_n, load_outputs_n, hold_busy} = 4'h6;
		repeat (3) @(negedge core_clk);
		chk("busy_reset", 24'h1, busy_oe);
		@(negedge core_clk);
		rst_b = 1'b1;
		wait_idle();
		chk("ground_reset", 24'h1, reference_ground);
		t_par_load();
		t_deselect();
		t_chain();
		t_defer();
		t_clear();
		t_queue();
		t_resets();
		close_out();
	end
endmodule
